/* File: design/analog_io_control_status_defines.svh */
`ifndef ANALOG_IO_CONTROL_STATUS_DEFINES_SVH
`define ANALOG_IO_CONTROL_STATUS_DEFINES_SVH

// host i/o byte offsets from the board base
`define CTRL_OFFS 5'h06
`define STATUS_OFFS 5'h18
`define DAC_DATA_OFFS 5'h04
`define ACQ_CLEAR_OFFS 5'h08

// control and status reset values
`define CTRL_RESET 16'h0000
`define WORD_ZERO 16'h0000

// status word field positions
`define ST_ACQ_DONE 15
`define ST_ACQ_ACTIVE 14
`define ST_HALF_N 13
`define ST_NONEMPTY 12

// output fifo word markers
`define W_SECOND_READ 15
`define W_BUFFER_END 14

// conversion fifo half level and output fifo depth
`define CONV_HALF_LEVEL 256
`define OUT_FIFO_DEPTH 16

`endif

/* File: design/analog_io_control_status_pkg.sv */
package analog_io_control_status_pkg;

   typedef struct packed {
      logic [1:0] clk_mode;
      logic out1_serial_en;
      logic out0_serial_link_en;
      logic [3:0] waveform_mode_sel;
      logic update_inhibit;
      logic double_buffer_off;
      logic stop_at_buffer_end;
      logic conv_fifo_half_request;
      logic counter_src3_route;
      logic counter_gate2_route;
      logic fifo_write_path;
      logic ext_trigger_mask;
   } ctrl_s;

   typedef enum logic [1:0] {
      ACQ_IDLE = 2'h1,
      ACQ_RUN = 2'h2
   } acq_state_e;

   typedef struct packed {
      ctrl_s ctrl;
      acq_state_e acq;
      logic acq_done;
      logic conv_req;
      logic [15:0] hold;
      logic [15:0] dac_out;
      logic second;
      logic halted;
      logic trig_prev;
      logic timed_irq;
      logic retx;
      logic [15:0] rdata;
   } top_s;

endpackage : analog_io_control_status_pkg

/* File: design/analog_io_control_status.sv */
`timescale 1ns/1ps
`default_nettype none
`include "analog_io_control_status_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module out_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = `OUT_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("out_fifo: depth must be a power of two of at least 2");
      end
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
   } fifo_s;

   fifo_s s_reg, s_next;
   logic push;
   logic pop;

   assign out_valid = (s_reg.count != '0);
   assign out_data = s_reg.mem[s_reg.rptr];
   assign pop = out_valid && out_ready;
   // a pop frees a slot in the same cycle, so a full fifo still accepts
   assign in_ready = (s_reg.count != (AW + 1)'(DEPTH)) || pop;
   assign push = in_valid && in_ready;
   assign level = s_reg.count;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wptr] = in_data;
         s_next.wptr = s_reg.wptr + 1'b1;
      end
      if (pop) begin
         s_next.rptr = s_reg.rptr + 1'b1;
      end
      s_next.count = s_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_fifo_count_bound: assert property (s_reg.count <= (AW + 1)'(DEPTH))
      else $error("fifo count above depth");
endmodule : out_fifo

////////////////////////////////////////////////////////////////////////////////
module analog_io_control_status #(
   parameter int CONV_LEVEL_W = 10,
   parameter int HALF_LEVEL = `CONV_HALF_LEVEL,
   parameter int OUT_DEPTH = `OUT_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [4:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic io_dack,
   input wire logic [15:0] io_wdata,
   output logic [15:0] io_rdata,
   output logic io_ready,
   input wire logic update_tick,
   output logic [15:0] dac_out_data,
   output logic dac_dma_req,
   output logic timed_irq,
   output logic output_halted,
   input wire logic serial_valid,
   input wire logic [15:0] serial_data,
   output logic serial_ready,
   output logic [2:0] counter_stop_sel,
   output logic counter2_restart,
   input wire logic scan_clock_sig,
   input wire logic counter_out1,
   input wire logic gate2_internal,
   output logic counter_src3,
   output logic counter_gate2,
   input wire logic ext_trigger_in_n,
   input wire logic acq_end_in,
   input wire logic overflow_in,
   input wire logic overrun_in,
   output logic acq_start,
   input wire logic [CONV_LEVEL_W-1:0] conv_fifo_level,
   input wire logic conversion_request_en,
   output logic conv_request
);
   import analog_io_control_status_pkg::*;

   initial begin
      if (HALF_LEVEL < 1 || HALF_LEVEL >= (1 << CONV_LEVEL_W) || OUT_DEPTH < 2) begin
         $error("analog_io_control_status: unsupported parameter values");
      end
   end

   localparam int OAW = $clog2(OUT_DEPTH);
   localparam logic [CONV_LEVEL_W-1:0] HALF_CNT = CONV_LEVEL_W'(HALF_LEVEL);
   localparam logic [OAW:0] OUT_FULL = (OAW + 1)'(OUT_DEPTH);
   localparam logic [OAW:0] OUT_HALF = (OAW + 1)'(OUT_DEPTH / 2);

   function automatic logic uses_fifo(input logic [3:0] m);
      return m[2:0] != 3'h0;
   endfunction : uses_fifo

   function automatic logic is_cyclic(input logic [3:0] m);
      return m[2:0] == 3'h3;
   endfunction : is_cyclic

   top_s s_reg, s_next;
   logic [3:0] mode;
   logic ctrl_wr;
   logic host_dac_wr;
   logic fifo_wr_req;
   logic direct_wr;
   logic trig_fire;
   logic acq_stop;
   logic conv_nonempty;
   logic conv_half;
   logic pop;
   logic recirc;
   logic f_in_valid;
   logic f_in_ready;
   logic [15:0] f_in_data;
   logic f_out_valid;
   logic [15:0] f_out_data;
   logic [OAW:0] f_level;
   logic [15:0] status_word;

   assign mode = s_reg.ctrl.waveform_mode_sel;
   assign ctrl_wr = io_wr && !io_dack && (io_addr == `CTRL_OFFS);
   assign host_dac_wr = io_wr && !io_dack && (io_addr == `DAC_DATA_OFFS);
   assign fifo_wr_req = (io_wr && io_dack) || (host_dac_wr && s_reg.ctrl.fifo_write_path);
   assign direct_wr = host_dac_wr && !s_reg.ctrl.fifo_write_path;
   assign trig_fire = s_reg.trig_prev && !ext_trigger_in_n && !s_reg.ctrl.ext_trigger_mask;
   assign acq_stop = acq_end_in || overflow_in || overrun_in;
   assign conv_nonempty = (conv_fifo_level != '0);
   assign conv_half = (conv_fifo_level >= HALF_CNT);

   // second read of a pair, or one read per accepted update
   assign pop = f_out_valid && uses_fifo(mode) && !s_reg.halted &&
                (s_reg.second || (update_tick && !s_reg.ctrl.update_inhibit));
   assign recirc = pop && is_cyclic(mode);
   assign f_in_valid = recirc || (fifo_wr_req && !s_reg.ctrl.update_inhibit);
   assign f_in_data = recirc ? f_out_data : io_wdata;
   // recirculation owns the fifo input; host fifo writes wait meanwhile
   assign io_ready = !fifo_wr_req || (f_in_ready && !recirc);

   out_fifo #(.WIDTH(16), .DEPTH(OUT_DEPTH)) u_out_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(pop),
      .out_data(f_out_data),
      .level(f_level)
   );

   always_comb begin
      status_word = `WORD_ZERO;
      status_word[`ST_ACQ_DONE] = s_reg.acq_done;
      status_word[`ST_ACQ_ACTIVE] = (s_reg.acq == ACQ_RUN);
      status_word[`ST_HALF_N] = !conv_half;
      status_word[`ST_NONEMPTY] = conv_nonempty;
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.trig_prev = ext_trigger_in_n;
      s_next.timed_irq = update_tick && (mode == 4'h8);
      s_next.retx = 1'b0;
      s_next.second = 1'b0;

      if (ctrl_wr) begin
         s_next.ctrl = ctrl_s'(io_wdata);
         s_next.halted = 1'b0;
      end

      unique case (s_reg.acq)
         ACQ_IDLE: begin
            if (trig_fire) begin
               s_next.acq = ACQ_RUN;
            end
         end
         ACQ_RUN: begin
            if (acq_stop) begin
               s_next.acq = ACQ_IDLE;
            end
         end
         default: begin
            s_next.acq = ACQ_IDLE;
         end
      endcase

      // the end event wins over a clear strobe in the same cycle
      if (io_wr && !io_dack && (io_addr == `ACQ_CLEAR_OFFS)) begin
         s_next.acq_done = 1'b0;
      end
      if ((s_reg.acq == ACQ_RUN) && acq_stop) begin
         s_next.acq_done = 1'b1;
      end

      if (!conv_nonempty) begin
         s_next.conv_req = 1'b0;
      end else if (!s_reg.ctrl.conv_fifo_half_request) begin
         s_next.conv_req = 1'b1;
      end else if (conv_half || s_reg.acq_done) begin
         s_next.conv_req = 1'b1;
      end

      if (direct_wr) begin
         if (s_reg.ctrl.double_buffer_off) begin
            s_next.dac_out = io_wdata;
         end else begin
            s_next.hold = io_wdata;
         end
      end
      if (update_tick && !s_reg.ctrl.update_inhibit && !s_reg.ctrl.double_buffer_off &&
          !uses_fifo(mode)) begin
         s_next.dac_out = s_reg.hold;
      end

      if (pop) begin
         s_next.dac_out = f_out_data;
         s_next.second = mode[3] && f_out_data[`W_SECOND_READ] && !s_reg.second;
         if (is_cyclic(mode) && f_out_data[`W_BUFFER_END]) begin
            s_next.retx = 1'b1;
            if (s_reg.ctrl.stop_at_buffer_end) begin
               s_next.halted = 1'b1;
            end
         end
      end

      if (s_reg.ctrl.out0_serial_link_en && serial_valid) begin
         s_next.dac_out = serial_data;
      end

      if (io_rd) begin
         s_next.rdata = (io_addr == `STATUS_OFFS) ? status_word : `WORD_ZERO;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_reg.ctrl <= ctrl_s'(`CTRL_RESET);
         s_reg.acq <= ACQ_IDLE;
         s_reg.acq_done <= 1'b0;
         s_reg.conv_req <= 1'b0;
         s_reg.hold <= `WORD_ZERO;
         s_reg.dac_out <= `WORD_ZERO;
         s_reg.second <= 1'b0;
         s_reg.halted <= 1'b0;
         s_reg.trig_prev <= 1'b1;
         s_reg.timed_irq <= 1'b0;
         s_reg.retx <= 1'b0;
         s_reg.rdata <= `WORD_ZERO;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign io_rdata = s_reg.rdata;
   assign dac_out_data = s_reg.dac_out;
   assign timed_irq = s_reg.timed_irq;
   assign output_halted = s_reg.halted;
   assign serial_ready = s_reg.ctrl.out0_serial_link_en;
   assign acq_start = trig_fire && (s_reg.acq == ACQ_IDLE);
   assign conv_request = conversion_request_en && s_reg.conv_req;

   always_comb begin
      dac_dma_req = 1'b0;
      if (mode[2:0] == 3'h1) begin
         dac_dma_req = (f_level != OUT_FULL);
      end else if (mode[2:0] == 3'h2) begin
         dac_dma_req = (f_level < OUT_HALF);
      end
   end

   always_comb begin
      counter_stop_sel = 3'h0;
      unique case (mode[2:0])
         3'h4: counter_stop_sel = 3'h1;
         3'h5: counter_stop_sel = 3'h2;
         3'h6: counter_stop_sel = 3'h4;
         3'h7: counter_stop_sel = 3'h1;
         3'h0, 3'h1, 3'h2, 3'h3: counter_stop_sel = 3'h0;
      endcase
   end

   assign counter2_restart = (mode[2:0] == 3'h7);
   assign counter_src3 = s_reg.ctrl.counter_src3_route ? s_reg.retx : scan_clock_sig;
   assign counter_gate2 = s_reg.ctrl.counter_gate2_route ? counter_out1 : gate2_internal;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_ctrl_capture: assert property (ctrl_wr |=> s_reg.ctrl == ctrl_s'($past(io_wdata)))
      else $error("control word not captured");
   chk_ctrl_hold: assert property (!ctrl_wr |=> $stable(s_reg.ctrl))
      else $error("control word changed without a write");
   chk_done_sticky: assert property (s_reg.acq_done && !(io_wr && !io_dack && io_addr == `ACQ_CLEAR_OFFS)
      |=> s_reg.acq_done)
      else $error("done bit cleared without strobe");
   chk_done_set: assert property ((s_reg.acq == ACQ_RUN) && acq_stop |=> s_reg.acq_done && s_reg.acq == ACQ_IDLE)
      else $error("acquisition end not flagged");
   chk_trig_mask: assert property (s_reg.ctrl.ext_trigger_mask && s_reg.acq == ACQ_IDLE && !ctrl_wr
      |=> s_reg.acq == ACQ_IDLE)
      else $error("masked trigger started acquisition");
   chk_status_read: assert property (io_rd && io_addr == `STATUS_OFFS
      |=> io_rdata[`ST_HALF_N] == !($past(conv_fifo_level) >= HALF_CNT)
      && io_rdata[`ST_NONEMPTY] == ($past(conv_fifo_level) != '0))
      else $error("status word fill bits wrong");
   chk_half_drop: assert property (s_reg.conv_req && s_reg.ctrl.conv_fifo_half_request && conv_nonempty && !ctrl_wr
      |=> s_reg.conv_req)
      else $error("half request dropped before empty");
   chk_single_req: assert property (!s_reg.ctrl.conv_fifo_half_request && !ctrl_wr
      |=> s_reg.conv_req == ($past(conv_fifo_level) != '0))
      else $error("single request does not follow fill");
   chk_inhibit_pop: assert property (s_reg.ctrl.update_inhibit && !s_reg.second |-> !pop)
      else $error("fifo read while updates inhibited");
   chk_src3_route: assert property (!s_reg.ctrl.counter_src3_route |-> counter_src3 == scan_clock_sig)
      else $error("source 3 not on scan clock");
   chk_direct_bypass: assert property (direct_wr && s_reg.ctrl.double_buffer_off && !pop && !serial_valid
      |=> dac_out_data == $past(io_wdata))
      else $error("direct write not passed through");
   chk_dma_single: assert property (mode[2:0] == 3'h1 |-> dac_dma_req == (f_level != OUT_FULL))
      else $error("single dma request wrong");
endmodule : analog_io_control_status

`default_nettype wire

/* File: design/placeholder_unused.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verif/conv_fifo_model.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module conv_fifo_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic push,
   input wire logic drain,
   output logic [9:0] level
);
   // conversions arrive on push; the host drains one result a cycle until empty
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         level <= 10'h000;
      end else if (push) begin
         level <= level + 10'h001;
      end else if (drain && level != 10'h000) begin
         level <= level - 10'h001;
      end
   end
endmodule : conv_fifo_model

`default_nettype wire

/* File: verif/analog_io_control_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "analog_io_control_status_defines.svh"
`define check(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end

////////////////////////////////////////////////////////////////////////////////
module analog_io_control_status_tb_top;
   logic core_clk, rst, io_wr, io_rd, io_dack, update_tick, serial_valid, scan_clock_sig;
   logic counter_out1, gate2_internal, ext_trigger_in_n, acq_end_in, overflow_in, overrun_in;
   logic conversion_request_en, push, drain, rdy, irq_seen, src3_seen;
   logic [4:0] io_addr;
   logic [15:0] io_wdata, serial_data, io_rdata, dac_out_data, rd_v;
   logic io_ready, dac_dma_req, timed_irq, output_halted, serial_ready, counter2_restart;
   logic counter_src3, counter_gate2, acq_start, conv_request;
   logic [2:0] counter_stop_sel;
   logic [9:0] conv_fifo_level;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   wire [6:0] row_seen = {counter2_restart, counter_stop_sel, serial_ready, counter_src3, counter_gate2};
   logic [15:0] row_ctrl [5] = '{16'h1404, 16'h0508, 16'h0e00, 16'h0f04, 16'h0000};
   logic [6:0] row_exp [5] = '{7'h0f, 7'h10, 7'h22, 7'h4b, 7'h02};

   analog_io_control_status #(.HALF_LEVEL(4)) analog_io_control_status_i (
      .core_clk(core_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_dack(io_dack), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ready(io_ready),
      .update_tick(update_tick), .dac_out_data(dac_out_data), .dac_dma_req(dac_dma_req),
      .timed_irq(timed_irq), .output_halted(output_halted), .serial_valid(serial_valid),
      .serial_data(serial_data), .serial_ready(serial_ready), .counter_stop_sel(counter_stop_sel),
      .counter2_restart(counter2_restart), .scan_clock_sig(scan_clock_sig), .counter_out1(counter_out1),
      .gate2_internal(gate2_internal), .counter_src3(counter_src3), .counter_gate2(counter_gate2),
      .ext_trigger_in_n(ext_trigger_in_n), .acq_end_in(acq_end_in), .overflow_in(overflow_in),
      .overrun_in(overrun_in), .acq_start(acq_start), .conv_fifo_level(conv_fifo_level),
      .conversion_request_en(conversion_request_en), .conv_request(conv_request));

   conv_fifo_model conv_fifo_model_i (.core_clk(core_clk), .rst(rst), .push(push), .drain(drain),
      .level(conv_fifo_level));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   // hang guard, the whole sequence needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge core_clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      #1 rdy = io_ready;
      @(negedge core_clk);
      io_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a);
      @(negedge core_clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge core_clk);
      io_rd = 1'b0;
      @(negedge core_clk);
      rd_v = io_rdata;
   endtask : rd

   // one update pulse per round, timed interrupt watched over the two cycles after it
   task automatic tick(input int n);
      irq_seen = 1'b0;
      src3_seen = 1'b0;
      repeat (n) begin
         @(negedge core_clk);
         update_tick = 1'b1;
         @(negedge core_clk);
         update_tick = 1'b0;
         irq_seen |= timed_irq;
         src3_seen |= counter_src3;
         @(negedge core_clk);
         irq_seen |= timed_irq;
         src3_seen |= counter_src3;
      end
   endtask : tick

   task automatic lvl(input logic up, input int n);
      @(negedge core_clk);
      push = up;
      drain = ~up;
      repeat (n) @(negedge core_clk);
      push = 1'b0;
      drain = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : lvl

   initial begin
      rst = 1'b1;
      {io_wr, io_rd, io_dack, update_tick, serial_valid, acq_end_in, push, drain} = 8'h00;
      {overflow_in, overrun_in, gate2_internal} = 3'h0;
      {scan_clock_sig, counter_out1, ext_trigger_in_n, conversion_request_en} = 4'hf;
      io_addr = 5'h00;
      io_wdata = 16'h0000;
      serial_data = 16'h0000;
      repeat (16) @(negedge core_clk);
      rst = 1'b0;
      rd(`STATUS_OFFS);
      `check("status after reset", 16'h2000, rd_v)
      for (int i = 0; i < 5; i++) begin
         wr(`CTRL_OFFS, row_ctrl[i]);
         @(negedge core_clk);
         `check("mode row", row_exp[i], row_seen)
      end
      rd(`CTRL_OFFS);
      `check("control read", 16'h0000, rd_v)
      rd(5'h1e);
      `check("unmapped read", 16'h0000, rd_v)
      wr(`CTRL_OFFS, 16'h0040);
      wr(`DAC_DATA_OFFS, 16'h1234);
      `check("unbuffered write", 16'h1234, dac_out_data)
      wr(`CTRL_OFFS, 16'h0080);
      wr(`DAC_DATA_OFFS, 16'h5678);
      tick(1);
      `check("inhibited update", 16'h1234, dac_out_data)
      wr(`CTRL_OFFS, 16'h0000);
      tick(1);
      `check("buffered update", 16'h5678, dac_out_data)
      `check("no timed irq", 1'b0, irq_seen)
      wr(`CTRL_OFFS, 16'h0800);
      tick(1);
      `check("timed irq", 1'b1, irq_seen)
      for (int i = 0; i < 2; i++) begin
         wr(`CTRL_OFFS, i ? 16'h0040 : 16'h1040);
         @(negedge core_clk);
         serial_valid = 1'b1;
         serial_data = i ? 16'haaaa : 16'hbeef;
         @(negedge core_clk);
         serial_valid = 1'b0;
         `check("serial link", 16'hbeef, dac_out_data)
      end
      wr(`CTRL_OFFS, 16'h0102);
      `check("single request", 1'b1, dac_dma_req)
      io_dack = 1'b1;
      wr(5'h1f, 16'h0001);
      io_dack = 1'b0;
      for (int i = 2; i <= 16; i++) wr(`DAC_DATA_OFFS, 16'(i));
      `check("fifo accepts", 1'b1, rdy)
      wr(`DAC_DATA_OFFS, 16'h0011);
      `check("fifo full refuses", 1'b0, rdy)
      `check("full no request", 1'b0, dac_dma_req)
      tick(1);
      `check("dma word first", 16'h0001, dac_out_data)
      tick(1);
      `check("one read per tick", 16'h0002, dac_out_data)
      tick(14);
      `check("fifo drained", 16'h0010, dac_out_data)
      wr(`CTRL_OFFS, 16'h0202);
      @(negedge core_clk);
      `check("half flag request", 1'b1, dac_dma_req)
      // two-read pair then buffer end; halt only with the stop bit set
      wr(`CTRL_OFFS, 16'h0b2a);
      wr(`DAC_DATA_OFFS, 16'h8001);
      wr(`DAC_DATA_OFFS, 16'h4007);
      tick(1);
      @(negedge core_clk);
      `check("cyclic stop", 17'h1_4007, {output_halted, dac_out_data})
      `check("retransmit on source 3", 2'h2, {src3_seen, counter_src3})
      wr(`CTRL_OFFS, 16'h0b0a);
      tick(1);
      @(negedge core_clk);
      `check("cyclic restart", 17'h0_4007, {output_halted, dac_out_data})
      wr(`CTRL_OFFS, 16'h0000);
      lvl(1'b1, 1);
      `check("single conv request", 1'b1, conv_request)
      rd(`STATUS_OFFS);
      `check("status one queued", 16'h3000, rd_v)
      lvl(1'b0, 2);
      `check("request dropped empty", 1'b0, conv_request)
      wr(`CTRL_OFFS, 16'h0010);
      lvl(1'b1, 3);
      `check("below half no request", 1'b0, conv_request)
      lvl(1'b1, 1);
      `check("half request", 1'b1, conv_request)
      rd(`STATUS_OFFS);
      `check("status half", 16'h1000, rd_v)
      lvl(1'b0, 1);
      `check("request kept", 1'b1, conv_request)
      lvl(1'b0, 4);
      `check("request released", 1'b0, conv_request)
      for (int i = 0; i < 2; i++) begin
         wr(`CTRL_OFFS, i ? 16'h0010 : 16'h0011);
         @(negedge core_clk);
         ext_trigger_in_n = 1'b0;
         #1 `check("trigger start", 1'(i), acq_start)
         @(negedge core_clk);
         ext_trigger_in_n = 1'b1;
      end
      rd(`STATUS_OFFS);
      `check("acq running", 16'h6000, rd_v)
      lvl(1'b1, 1);
      @(negedge core_clk);
      acq_end_in = 1'b1;
      @(negedge core_clk);
      acq_end_in = 1'b0;
      rd(`STATUS_OFFS);
      `check("acq done", 16'hb000, rd_v)
      `check("done request", 1'b1, conv_request)
      wr(`ACQ_CLEAR_OFFS, 16'h0000);
      rd(`STATUS_OFFS);
      `check("done cleared", 16'h3000, rd_v)
      @(negedge core_clk);
      rst = 1'b1;
      @(negedge core_clk);
      rst = 1'b0;
      rd(`STATUS_OFFS);
      `check("status second reset", 16'h2000, rd_v)
      `check("ctrl second reset", 4'h0, {serial_ready, counter_stop_sel})
      conclude();
   end
endmodule : analog_io_control_status_tb_top

`default_nettype wire
